// ===== pkg/rcpll_pkg.sv
// Constants and types shared by the reset configuration and PLL ratio block.
package rcpll_pkg;

	// ------------------------------------------------------------------
	// Strap pin and reset configuration word layout
	// ------------------------------------------------------------------
	localparam int unsigned STRAP_W = 2;
	localparam int unsigned STRAP_CLKIN_DIV = 0;
	localparam int unsigned STRAP_AGENT = 1;
	localparam int unsigned RCW_W = 32;
	localparam int unsigned RCW_LBUS_BIT = 31;
	localparam int unsigned RCW_DRAM_BIT = 30;
	localparam int unsigned RCW_MULT_LSB = 24;
	localparam int unsigned MULT_W = 4;
	localparam logic [3:0] MULT_MIN = 4'h2;
	localparam logic [3:0] MULT_MAX = 4'h6;

	// ------------------------------------------------------------------
	// Register map, byte offsets within the slave window
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CAPT = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_VCO_DIV = 8'h08;
	localparam logic [7:0] OFS_IN_MHZ = 8'h0C;
	localparam logic [7:0] OFS_RATIO = 8'h10;
	localparam logic [7:0] OFS_VCO_MHZ = 8'h14;
	localparam logic [3:0] VCO_DIV_RST = 4'h2;
	localparam logic [7:0] IN_MHZ_RST = 8'h19;
	localparam logic [15:0] VCO_MIN_MHZ = 16'h01C2;
	localparam logic [15:0] VCO_MAX_MHZ = 16'h02EE;

	// ------------------------------------------------------------------
	// Status register bit positions
	// ------------------------------------------------------------------
	localparam int unsigned ST_CFG_VALID = 0;
	localparam int unsigned ST_RATIO_OK = 1;
	localparam int unsigned ST_VCO_OK = 2;
	localparam int unsigned ST_CLKIN_DIV = 3;
	localparam int unsigned ST_AGENT = 4;
	localparam int unsigned ST_TAP_RESET = 5;
	localparam int unsigned ST_HARD_RESET_N = 6;

	// ------------------------------------------------------------------
	// TAP reset and capture sequencing
	// ------------------------------------------------------------------
	localparam logic [2:0] TAP_TMS_RESET_CNT = 3'h5;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic {CAP_IN_RESET, CAP_HELD} rcpll_cap_state_t;

endpackage : rcpll_pkg

// ===== design/rcpll_tap_reset.sv
// Tracks whether the test access port is held in its reset state.
`timescale 1ns/1ns
module rcpll_tap_reset (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Synchronised test signals
	input wire logic tck_s,
	input wire logic tms_s,
	input wire logic trst_n_s,
	// Result
	output logic tap_reset_r
);

	logic tck_d_r;
	logic tck_d_nxt;
	logic [2:0] tms_cnt_r;
	logic [2:0] tms_cnt_nxt;
	logic tap_reset_nxt;
	logic tck_rise;

	// A rising test clock is seen as the sampled level going from low to high.
	assign tck_rise = tck_s & ~tck_d_r;

	// Five test clock rises with mode select high force reset, as does trst.
	always_comb begin
		tck_d_nxt = tck_s;
		tms_cnt_nxt = tms_cnt_r;
		tap_reset_nxt = tap_reset_r;
		if (!trst_n_s) begin
			tms_cnt_nxt = rcpll_pkg::TAP_TMS_RESET_CNT;
			tap_reset_nxt = 1'b1;
		end else if (tck_rise) begin
			if (tms_s) begin
				if (tms_cnt_r != rcpll_pkg::TAP_TMS_RESET_CNT) begin
					tms_cnt_nxt = tms_cnt_r + 3'h1;
				end
				if (tms_cnt_r >= rcpll_pkg::TAP_TMS_RESET_CNT - 3'h1) begin
					tap_reset_nxt = 1'b1;
				end
			end else begin
				tms_cnt_nxt = 3'h0;
				tap_reset_nxt = 1'b0;
			end
		end
	end

	// Registers of the tracker; the port starts out in reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tck_d_r <= 1'b0;
			tms_cnt_r <= rcpll_pkg::TAP_TMS_RESET_CNT;
			tap_reset_r <= 1'b1;
		end else begin
			tck_d_r <= tck_d_nxt;
			tms_cnt_r <= tms_cnt_nxt;
			tap_reset_r <= tap_reset_nxt;
		end
	end

endmodule : rcpll_tap_reset

// ===== design/rcpll_top.sv
// Reset configuration capture, PLL ratio selection and register slave.
`timescale 1ns/1ns
module rcpll_top #(
	parameter int unsigned STRAP_W = rcpll_pkg::STRAP_W
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Reset pins and configuration word
	input wire logic power_on_reset_n,
	input wire logic hard_reset_n,
	input wire logic [31:0] reset_cfg_word_low,
	// Configuration strap pins and their normal function
	input wire logic [STRAP_W-1:0] strap_pin_in,
	output logic [STRAP_W-1:0] strap_pin_out,
	output logic [STRAP_W-1:0] strap_pin_oe_n,
	input wire logic [STRAP_W-1:0] strap_func_out,
	input wire logic [STRAP_W-1:0] strap_func_oe_n,
	// Test access pins
	input wire logic tck,
	input wire logic tms,
	input wire logic trst_n,
	// Clock control results
	output logic cfg_valid,
	output logic ref_sel_agent,
	output logic clkin_div,
	output logic [3:0] csb_ratio,
	output logic [7:0] vco_mult,
	output logic tap_reset
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (STRAP_W < rcpll_pkg::STRAP_W) begin : g_chk
		$error("rcpll_top needs at least two strap pins.");
	end

	localparam int unsigned SYNC_W = STRAP_W + 5;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic [SYNC_W-1:0] sync1_nxt;
	logic [SYNC_W-1:0] sync2_nxt;
	logic por_n_s;
	logic hrst_n_s;
	logic tck_s;
	logic tms_s;
	logic trst_n_s;
	logic [STRAP_W-1:0] strap_s;

	// Every pin passes two flops; only the second stage is read.
	always_comb begin
		sync1_nxt = {strap_pin_in, trst_n, tms, tck, hard_reset_n,
			power_on_reset_n};
		sync2_nxt = sync1_r;
	end

	// Synchroniser stages.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	assign por_n_s = sync2_r[0];
	assign hrst_n_s = sync2_r[1];
	assign tck_s = sync2_r[2];
	assign tms_s = sync2_r[3];
	assign trst_n_s = sync2_r[4];
	assign strap_s = sync2_r[SYNC_W-1:5];

	// ------------------------------------------------------------------
	// Configuration capture
	// ------------------------------------------------------------------
	rcpll_pkg::rcpll_cap_state_t cap_st_r;
	rcpll_pkg::rcpll_cap_state_t cap_st_nxt;
	logic [STRAP_W-1:0] strap_hold_r;
	logic [STRAP_W-1:0] strap_hold_nxt;
	logic [STRAP_W-1:0] strap_capt_r;
	logic [STRAP_W-1:0] strap_capt_nxt;
	logic [31:0] rcw_capt_r;
	logic [31:0] rcw_capt_nxt;

	// Straps are followed while hard reset is low and frozen at power-on
	// release; the held values then stay until the next power-on release.
	always_comb begin
		cap_st_nxt = cap_st_r;
		strap_hold_nxt = strap_hold_r;
		strap_capt_nxt = strap_capt_r;
		rcw_capt_nxt = rcw_capt_r;
		if (!hrst_n_s) begin
			strap_hold_nxt = strap_s;
		end
		case (cap_st_r)
			rcpll_pkg::CAP_IN_RESET: begin
				if (por_n_s) begin
					cap_st_nxt = rcpll_pkg::CAP_HELD;
					strap_capt_nxt = strap_hold_r;
					rcw_capt_nxt = reset_cfg_word_low;
				end
			end
			rcpll_pkg::CAP_HELD: begin
				if (!por_n_s) begin
					cap_st_nxt = rcpll_pkg::CAP_IN_RESET;
				end
			end
			default: begin
				cap_st_nxt = rcpll_pkg::CAP_IN_RESET;
			end
		endcase
	end

	// Capture registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_st_r <= rcpll_pkg::CAP_IN_RESET;
			strap_hold_r <= '0;
			strap_capt_r <= '0;
			rcw_capt_r <= 32'h00000000;
		end else begin
			cap_st_r <= cap_st_nxt;
			strap_hold_r <= strap_hold_nxt;
			strap_capt_r <= strap_capt_nxt;
			rcw_capt_r <= rcw_capt_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Ratio and VCO derivation
	// ------------------------------------------------------------------
	logic [3:0] vco_div_r;
	logic [7:0] in_mhz_r;
	logic [3:0] mult_code;
	logic ratio_ok;
	logic vco_double;
	logic [7:0] prod;
	logic [15:0] vco_mhz;
	logic vco_ok;
	logic cfg_valid_nxt;
	logic ref_sel_nxt;
	logic clkin_div_nxt;
	logic [3:0] csb_ratio_nxt;
	logic [7:0] vco_mult_nxt;
	logic [15:0] vco_mhz_r;
	logic vco_ok_r;
	logic ratio_ok_r;

	assign mult_code = rcw_capt_r[rcpll_pkg::RCW_MULT_LSB +: rcpll_pkg::MULT_W];
	assign vco_double = rcw_capt_r[rcpll_pkg::RCW_DRAM_BIT]
		| rcw_capt_r[rcpll_pkg::RCW_LBUS_BIT];
	assign vco_mhz = {8'h00, in_mhz_r} * {8'h00, vco_mult_nxt};

	// Everything here depends only on the held capture and software regs.
	always_comb begin
		ratio_ok = (mult_code >= rcpll_pkg::MULT_MIN)
			&& (mult_code <= rcpll_pkg::MULT_MAX);
		csb_ratio_nxt = ratio_ok ? mult_code : 4'h0;
		prod = {4'h0, csb_ratio_nxt} * {4'h0, vco_div_r};
		vco_mult_nxt = vco_double ? {prod[6:0], 1'b0} : prod;
		vco_ok = (vco_mhz >= rcpll_pkg::VCO_MIN_MHZ)
			&& (vco_mhz <= rcpll_pkg::VCO_MAX_MHZ);
		cfg_valid_nxt = (cap_st_r == rcpll_pkg::CAP_HELD);
		ref_sel_nxt = strap_capt_r[rcpll_pkg::STRAP_AGENT];
		clkin_div_nxt = strap_capt_r[rcpll_pkg::STRAP_CLKIN_DIV];
	end

	// Registered results.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_valid <= 1'b0;
			ref_sel_agent <= 1'b0;
			clkin_div <= 1'b0;
			csb_ratio <= 4'h0;
			vco_mult <= 8'h00;
			vco_mhz_r <= 16'h0000;
			vco_ok_r <= 1'b0;
			ratio_ok_r <= 1'b0;
		end else begin
			cfg_valid <= cfg_valid_nxt;
			ref_sel_agent <= ref_sel_nxt;
			clkin_div <= clkin_div_nxt;
			csb_ratio <= csb_ratio_nxt;
			vco_mult <= vco_mult_nxt;
			vco_mhz_r <= vco_mhz;
			vco_ok_r <= vco_ok;
			ratio_ok_r <= ratio_ok;
		end
	end

	// ------------------------------------------------------------------
	// Strap pin drivers
	// ------------------------------------------------------------------
	logic [STRAP_W-1:0] pin_out_nxt;
	logic [STRAP_W-1:0] pin_oe_n_nxt;

	// Receivers only while reset or uncaptured; then the normal function.
	always_comb begin
		pin_out_nxt = strap_func_out;
		pin_oe_n_nxt = strap_func_oe_n;
		if (!hrst_n_s || cap_st_r != rcpll_pkg::CAP_HELD) begin
			pin_oe_n_nxt = '1;
		end
	end

	// Pin output registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_pin_out <= '0;
			strap_pin_oe_n <= '1;
		end else begin
			strap_pin_out <= pin_out_nxt;
			strap_pin_oe_n <= pin_oe_n_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Test access reset tracking
	// ------------------------------------------------------------------
	rcpll_tap_reset u_tap (
		.hclk(hclk),
		.hresetn(hresetn),
		.tck_s(tck_s),
		.tms_s(tms_s),
		.trst_n_s(trst_n_s),
		.tap_reset_r(tap_reset)
	);

	// ------------------------------------------------------------------
	// AHB-Lite register slave
	// ------------------------------------------------------------------
	logic wr_pend_r;
	logic wr_pend_nxt;
	logic [7:0] wr_ofs_r;
	logic [7:0] wr_ofs_nxt;
	logic [3:0] vco_div_nxt;
	logic [7:0] in_mhz_nxt;
	logic [31:0] rdata_nxt;
	logic [31:0] status;
	logic [7:0] ofs;
	logic take;
	logic [3:0] div_now;
	logic [7:0] mhz_now;

	assign take = hsel && hready && (htrans == rcpll_pkg::HTRANS_NONSEQ);
	assign ofs = {haddr[7:2], 2'b00};

	// Writes land in the data phase; reads forward a write just landing.
	always_comb begin
		wr_pend_nxt = take && hwrite;
		wr_ofs_nxt = ofs;
		vco_div_nxt = vco_div_r;
		in_mhz_nxt = in_mhz_r;
		if (wr_pend_r && wr_ofs_r == rcpll_pkg::OFS_VCO_DIV) begin
			vco_div_nxt = hwdata[3:0];
		end
		if (wr_pend_r && wr_ofs_r == rcpll_pkg::OFS_IN_MHZ) begin
			in_mhz_nxt = hwdata[7:0];
		end
		div_now = vco_div_nxt;
		mhz_now = in_mhz_nxt;
		status = 32'h00000000;
		status[rcpll_pkg::ST_CFG_VALID] = cfg_valid;
		status[rcpll_pkg::ST_RATIO_OK] = ratio_ok_r;
		status[rcpll_pkg::ST_VCO_OK] = vco_ok_r;
		status[rcpll_pkg::ST_CLKIN_DIV] = clkin_div;
		status[rcpll_pkg::ST_AGENT] = ref_sel_agent;
		status[rcpll_pkg::ST_TAP_RESET] = tap_reset;
		status[rcpll_pkg::ST_HARD_RESET_N] = ~hrst_n_s;
		rdata_nxt = hrdata;
		if (take && !hwrite) begin
			case (ofs)
				rcpll_pkg::OFS_CAPT: rdata_nxt = rcw_capt_r;
				rcpll_pkg::OFS_STATUS: rdata_nxt = status;
				rcpll_pkg::OFS_VCO_DIV: rdata_nxt = {28'h0000000, div_now};
				rcpll_pkg::OFS_IN_MHZ: rdata_nxt = {24'h000000, mhz_now};
				rcpll_pkg::OFS_RATIO: rdata_nxt = {16'h0000, vco_mult,
					4'h0, csb_ratio};
				rcpll_pkg::OFS_VCO_MHZ: rdata_nxt = {16'h0000, vco_mhz_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// Bus registers; the slave never stalls and always answers OKAY.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_ofs_r <= 8'h00;
			vco_div_r <= rcpll_pkg::VCO_DIV_RST;
			in_mhz_r <= rcpll_pkg::IN_MHZ_RST;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_ofs_r <= wr_ofs_nxt;
			vco_div_r <= vco_div_nxt;
			in_mhz_r <= in_mhz_nxt;
			hrdata <= rdata_nxt;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

endmodule : rcpll_top

// ===== bench/rcpll_checker.sv
// Port assertions for the reset configuration and PLL ratio block.
`timescale 1ns/1ns
module rcpll_checker #(
	parameter int unsigned STRAP_W = 2
) (
	// Clock, reset and bus answer
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	// Reset and test pins
	input wire logic power_on_reset_n,
	input wire logic hard_reset_n,
	input wire logic trst_n,
	// Strap pins
	input wire logic [STRAP_W-1:0] strap_pin_out,
	input wire logic [STRAP_W-1:0] strap_pin_oe_n,
	input wire logic [STRAP_W-1:0] strap_func_out,
	input wire logic [STRAP_W-1:0] strap_func_oe_n,
	// Results
	input wire logic cfg_valid,
	input wire logic ref_sel_agent,
	input wire logic clkin_div,
	input wire logic [3:0] csb_ratio,
	input wire logic [7:0] vco_mult,
	input wire logic tap_reset
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Bus answers at once and always OKAY.
	a_resp_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not okay");
	// Pins float as inputs while hard reset is held.
	a_oe_hard: assert property (
		!hard_reset_n [*4] |-> &strap_pin_oe_n)
		else $error("strap pin driven in hard reset");
	// Only supported factors or zero appear.
	a_ratio_code: assert property (
		cfg_valid |-> csb_ratio inside {4'h0, [4'h2:4'h6]})
		else $error("unsupported ratio shown");
	// Held values do not move while the capture stands.
	a_cfg_hold: assert property (
		cfg_valid && $past(cfg_valid) && $past(cfg_valid, 2)
		|-> $stable(csb_ratio) && $stable(clkin_div)
		&& $stable(ref_sel_agent))
		else $error("captured value changed");
	// VCO factor is a whole multiple of the ratio.
	a_mult_div: assert property (
		(cfg_valid && $stable(csb_ratio)) [*3]
		|-> (csb_ratio == 4'h0) ? (vco_mult == 8'h0)
		: (vco_mult % csb_ratio == 8'h0))
		else $error("vco factor not a multiple");
	// Test reset pin forces the port into reset.
	a_trst_tap: assert property (!trst_n [*4] |-> tap_reset)
		else $error("tap not reset by pin");
	// Capture appears only after power-on release.
	a_cfg_rise: assert property (
		$rose(cfg_valid) |-> $past(power_on_reset_n, 2))
		else $error("capture before power-on release");
	// Capture is withdrawn in power-on reset.
	a_cfg_drop: assert property (
		!power_on_reset_n [*5] |-> !cfg_valid)
		else $error("capture kept in power-on reset");
	// Pins return to their normal function after capture.
	a_pin_func: assert property (
		(hard_reset_n && power_on_reset_n && cfg_valid) [*4]
		|-> strap_pin_oe_n == $past(strap_func_oe_n)
		&& strap_pin_out == $past(strap_func_out))
		else $error("strap pin not in normal function");
endmodule : rcpll_checker

bind rcpll_top rcpll_checker #(.STRAP_W(STRAP_W)) i_chk (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
	.hresp(hresp), .power_on_reset_n(power_on_reset_n),
	.hard_reset_n(hard_reset_n), .trst_n(trst_n),
	.strap_pin_out(strap_pin_out), .strap_pin_oe_n(strap_pin_oe_n),
	.strap_func_out(strap_func_out), .strap_func_oe_n(strap_func_oe_n),
	.cfg_valid(cfg_valid), .ref_sel_agent(ref_sel_agent),
	.clkin_div(clkin_div), .csb_ratio(csb_ratio),
	.vco_mult(vco_mult), .tap_reset(tap_reset));

// ===== bench/rcpll_board.sv
// Board model: strap resistors, reset source and debugger test reset.
`timescale 1ns/1ns
module rcpll_board #(
	parameter int unsigned STRAP_W = 2
) (
	// Device strap pins
	input wire logic [STRAP_W-1:0] pin_out,
	input wire logic [STRAP_W-1:0] pin_oe_n,
	output logic [STRAP_W-1:0] pin_in,
	// Resistor choice and reset sources
	input wire logic [STRAP_W-1:0] pull_up,
	input wire logic por_n,
	input wire logic dbg_trst_n,
	output logic trst_n
);
	// A released pin settles to its resistor, a driven one to the device.
	always_comb begin
		for (int i = 0; i < STRAP_W; i++) begin
			pin_in[i] = pin_oe_n[i] ? pull_up[i] : pin_out[i];
		end
	end
	// Test reset held in power-on reset, yet the debugger may pull it too.
	assign trst_n = por_n & dbg_trst_n;
endmodule : rcpll_board

// ===== bench/rcpll_top_tb.sv
// Self-checking bench for the reset configuration and PLL ratio block.
`timescale 1ns/1ns
module rcpll_top_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, trst_n, cfg_valid, ref_sel, cdiv, tap_rst;
	logic por_n = 1'b0;
	logic hrst_n = 1'b0;
	logic [31:0] rcw = 32'h0;
	logic [1:0] pin_in, pin_out, pin_oe_n;
	logic [1:0] f_out = 2'h0;
	logic [1:0] f_oe_n = 2'h3;
	logic [1:0] pull = 2'h0;
	logic tck = 1'b0;
	logic tms = 1'b0;
	logic dbg_n = 1'b1;
	logic [3:0] ratio;
	logic [7:0] vmult;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int seed = 32'hC2D4F982;

	always #5 hclk = ~hclk;

	rcpll_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .power_on_reset_n(por_n),
		.hard_reset_n(hrst_n), .reset_cfg_word_low(rcw),
		.strap_pin_in(pin_in), .strap_pin_out(pin_out),
		.strap_pin_oe_n(pin_oe_n), .strap_func_out(f_out),
		.strap_func_oe_n(f_oe_n), .tck(tck), .tms(tms), .trst_n(trst_n),
		.cfg_valid(cfg_valid), .ref_sel_agent(ref_sel), .clkin_div(cdiv),
		.csb_ratio(ratio), .vco_mult(vmult), .tap_reset(tap_rst));
	rcpll_board i_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_in(pin_in), .pull_up(pull), .por_n(por_n),
		.dbg_trst_n(dbg_n), .trst_n(trst_n));

	// Compares one value and counts the result.
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One single AHB-Lite transfer, waiting on ready in both phases.
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= rcpll_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	// Reads a register and compares it.
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk($sformatf("reg %h", a), d, e);
	endtask : rdchk

	// One test clock period with the given mode select.
	task automatic tck_pulse(input logic m);
		tms <= m;
		repeat (4) @(posedge hclk);
		tck <= 1'b1;
		repeat (4) @(posedge hclk);
		tck <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask : tck_pulse

	// Power-on cycle presenting a word and strap resistors.
	task automatic power_cycle(input logic [31:0] w, input logic [1:0] p);
		logic [31:0] d;
		hrst_n <= 1'b0;
		por_n <= 1'b0;
		repeat (6) @(posedge hclk);
		chk("oe_n", {30'h0, pin_oe_n}, 32'h3);
		// Status shows hard reset active and no capture held.
		ahb(1'b0, rcpll_pkg::OFS_STATUS, 32'h0, d);
		chk("in reset", {30'h0, d[6], d[0]}, 32'h2);
		rcw <= w;
		pull <= p;
		repeat (6) @(posedge hclk);
		por_n <= 1'b1;
		for (int i = 0; i < 20 && cfg_valid !== 1'b1; i++) @(posedge hclk);
		hrst_n <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask : power_cycle

	// Expected ratio from a multiplier code.
	function automatic logic [3:0] exp_ratio(input logic [3:0] c);
		return (c >= rcpll_pkg::MULT_MIN && c <= rcpll_pkg::MULT_MAX) ?
			c : 4'h0;
	endfunction : exp_ratio

	// Ends the run with the verdict.
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	// Cuts a hang short.
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			test_done();
		end
	end

	// Main sequence.
	initial begin
		logic [31:0] w, r, d;
		logic [3:0] dv, er;
		logic [7:0] mz, em;
		logic [15:0] ev;
		logic vok;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk(rcpll_pkg::OFS_VCO_DIV, {28'h0, rcpll_pkg::VCO_DIV_RST});
		rdchk(rcpll_pkg::OFS_IN_MHZ, {24'h0, rcpll_pkg::IN_MHZ_RST});
		ahb(1'b1, rcpll_pkg::OFS_RATIO, 32'hFFFFFFFF, d);
		rdchk(rcpll_pkg::OFS_RATIO, 32'h0);
		rdchk(8'h18, 32'h0);
		$display("test registers done");
		for (int k = 0; k < 16; k++) begin
			w = $random(seed);
			r = $random(seed);
			w[27:24] = k[3:0];
			if (k[0]) w[31:30] = 2'h0;
			dv = (r[3:0] == 4'h0) ? 4'h1 : r[3:0];
			mz = r[15:8] | 8'h10;
			// Software keeps the VCO in range; code six meets the top end.
			if (k == 4 || k == 6) begin
				w[31:30] = 2'h0;
				dv = 4'h5;
				mz = rcpll_pkg::IN_MHZ_RST;
			end
			power_cycle(w, r[17:16]);
			ahb(1'b1, rcpll_pkg::OFS_VCO_DIV, {28'h0, dv}, d);
			ahb(1'b1, rcpll_pkg::OFS_IN_MHZ, {24'h0, mz}, d);
			repeat (3) @(posedge hclk);
			er = exp_ratio(k[3:0]);
			em = ({4'h0, er} * {4'h0, dv}) << (w[31] | w[30]);
			ev = {8'h0, mz} * {8'h0, em};
			vok = ev >= rcpll_pkg::VCO_MIN_MHZ && ev <= rcpll_pkg::VCO_MAX_MHZ;
			chk("ratio", {28'h0, ratio}, {28'h0, er});
			chk("vmult", {24'h0, vmult}, {24'h0, em});
			chk("ref", {31'h0, ref_sel}, {31'h0, r[17]});
			rdchk(rcpll_pkg::OFS_RATIO, {16'h0, em, 4'h0, er});
			rdchk(rcpll_pkg::OFS_VCO_MHZ, {16'h0, ev});
			rdchk(rcpll_pkg::OFS_STATUS, {25'h0, 2'h1, r[17:16], vok,
				er != 4'h0, 1'b1});
			rcw <= ~w;
			pull <= ~r[17:16];
			f_out <= r[19:18];
			f_oe_n <= r[21:20];
			repeat (8) @(posedge hclk);
			chk("held", {27'h0, cdiv, ratio}, {27'h0, r[16], er});
			rdchk(rcpll_pkg::OFS_CAPT, w);
			chk("pins", {28'h0, pin_oe_n, pin_out}, {28'h0, r[21:18]});
		end
		$display("test codes done");
		tck_pulse(1'b0);
		chk("tap", {31'h0, tap_rst}, 32'h0);
		repeat (4) tck_pulse(1'b1);
		chk("tap", {31'h0, tap_rst}, 32'h0);
		tck_pulse(1'b1);
		chk("tap", {31'h0, tap_rst}, 32'h1);
		tck_pulse(1'b0);
		dbg_n <= 1'b0;
		repeat (5) @(posedge hclk);
		chk("tap", {31'h0, tap_rst}, 32'h1);
		dbg_n <= 1'b1;
		$display("test tap done");
		test_done();
	end
endmodule : rcpll_top_tb
